/* design/afelm_ctrl.sv */
// APB register bank and control logic for line mode, sample sync and selective power
// Summary of operation
// - Line bit zero selects line sequential mode
// - Line mode forces mono one, channel red
// - Line mode disables green and blue gain
// - Cycle bit zero: pin clamps, internal selection
// - Cycle bit one: pin pulses advance colour
// - Auto-cycling: pin never clamps
// - Auto-cycling: internal clamp bit enables clamping
// - Force bit drives input mux from field
// - Internal colour field: red, green, blue
// - Forced input field: red, green, blue inputs
// - Detect off: strobe pin passes straight
// - Detect on: internal pulse replaces pin
// - Pulse delayed by programmed clock periods
// - Polarity bit picks falling or rising edge
// - Disable bits act only with selective mode
// - Bit one disables cell: R,G,B,ADC
// - Selective off: global enable governs power
// - Cycle reset write returns counter to red
`include "afelm_consts.svh"
`default_nettype none
module afelm_ctrl
  import afelm_pkg::*;
#(
  parameter int ADDR_W = `AFELM_ADDR_W
) (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Pins
  input wire logic clamp_cycle_pin_i,
  input wire logic sample_strobe_pin_i,
  // Internal controls to the analogue path
  output logic mono_o,
  output logic [1:0] mono_channel_o,
  output logic [1:0] input_mux_sel_o,
  output logic [1:0] gain_offset_sel_o,
  output logic clamp_enable_o,
  output logic timing_strobe_o,
  output logic [3:0] cell_enable_o
);
  logic [7:0] line_mode_colour_select;
  logic [7:0] sample_edge_detect_ctrl;
  logic [7:0] selective_power_disable;
  logic [7:0] base_setup;
  afelm_colour_e cycle_colour;
  logic clamp_meta, clamp_sync, clamp_prev;
  logic strobe_meta, strobe_sync;

  // APB decode
  wire access = psel_i & penable_i & ce_i;
  wire wr = access & pwrite_i;
  wire hit_line = (paddr_i == `AFELM_OFS_LINE);
  wire hit_sample = (paddr_i == `AFELM_OFS_SAMPLE);
  wire hit_power = (paddr_i == `AFELM_OFS_POWER);
  wire hit_cycrst = (paddr_i == `AFELM_OFS_CYCRST);
  wire hit_base = (paddr_i == `AFELM_OFS_BASE);
  wire hit_status = (paddr_i == `AFELM_OFS_STATUS);
  wire mapped = hit_line | hit_sample | hit_power | hit_cycrst | hit_base | hit_status;
  wire cycle_reset_wr = wr & hit_cycrst;

  assign pready_o = ce_i;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // Field extraction
  wire line_en = line_mode_colour_select[`AFELM_LINE_EN_BIT];
  wire cyc_sel = line_mode_colour_select[`AFELM_LINE_CYC_BIT];
  wire force_bit = line_mode_colour_select[`AFELM_LINE_FORCE_BIT];
  wire internal_clamp_enable = line_mode_colour_select[`AFELM_LINE_CLAMP_BIT];
  wire [1:0] internal_colour_select = line_mode_colour_select[`AFELM_LINE_ICOL_LSB +: 2];
  wire [1:0] forced_input_select = line_mode_colour_select[`AFELM_LINE_FSEL_LSB +: 2];
  wire sample_detect_enable = sample_edge_detect_ctrl[`AFELM_SMP_DET_BIT];
  wire [`AFELM_DLY_W-1:0] sample_pulse_delay = sample_edge_detect_ctrl[`AFELM_SMP_DLY_LSB +: `AFELM_DLY_W];
  wire edge_polarity_select = sample_edge_detect_ctrl[`AFELM_SMP_POL_BIT];
  wire [3:0] cell_disable_bits = selective_power_disable[3:0];
  wire global_enable = base_setup[`AFELM_BASE_EN_BIT];
  wire mono_flag = base_setup[`AFELM_BASE_MONO_BIT];
  wire selective_powerdown_enable = base_setup[`AFELM_BASE_SPD_BIT];
  wire [1:0] mono_channel_select = base_setup[`AFELM_BASE_MCH_LSB +: 2];

  // Cycle select and force bit count only in line mode
  wire auto_cycle = line_en & cyc_sel;
  wire force_input_enable = line_en & force_bit;
  wire clamp_rise = clamp_sync & ~clamp_prev;

  // Next values of the internal controls
  wire next_mono = line_en ? 1'b1 : mono_flag;
  wire [1:0] next_channel = line_en ? 2'b00 : mono_channel_select;
  wire [1:0] line_colour = auto_cycle ? cycle_colour : internal_colour_select;
  wire [1:0] next_gain_sel = line_en ? line_colour : mono_channel_select;
  wire [1:0] next_input_sel = force_input_enable ? forced_input_select : next_gain_sel;
  wire next_clamp = auto_cycle ? internal_clamp_enable : clamp_sync;
  wire [3:0] power_base = selective_powerdown_enable ? ~cell_disable_bits : {4{global_enable}};
  wire [3:0] next_cells = line_en ? (power_base & 4'h9) : power_base;
  wire delayed_pulse;
  wire next_strobe = sample_detect_enable ? delayed_pulse : strobe_sync;

  afelm_colour_e next_colour;
  always_comb begin
    case (cycle_colour)
      AFELM_RED: next_colour = AFELM_GREEN;
      AFELM_GREEN: next_colour = AFELM_BLUE;
      default: next_colour = AFELM_RED;
    endcase
  end

  afelm_sample_delay #(
    .DEPTH(`AFELM_DLY_DEPTH),
    .DLY_W(`AFELM_DLY_W)
  ) u_delay (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .level_i(strobe_sync),
    .rising_i(edge_polarity_select),
    .delay_i(sample_pulse_delay),
    .pulse_o(delayed_pulse)
  );

  // Pin synchronisers
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clamp_meta <= 1'b0;
      clamp_sync <= 1'b0;
      clamp_prev <= 1'b0;
      strobe_meta <= 1'b0;
      strobe_sync <= 1'b0;
    end else if (ce_i) begin
      clamp_meta <= clamp_cycle_pin_i;
      clamp_sync <= clamp_meta;
      clamp_prev <= clamp_sync;
      strobe_meta <= sample_strobe_pin_i;
      strobe_sync <= strobe_meta;
    end
  end

  // Register writes; reserved bits are kept at zero
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_mode_colour_select <= `AFELM_RST_LINE;
      sample_edge_detect_ctrl <= `AFELM_RST_SAMPLE;
      selective_power_disable <= `AFELM_RST_POWER;
      base_setup <= `AFELM_RST_BASE;
    end else if (wr) begin
      if (hit_line) begin
        line_mode_colour_select <= pwdata_i[7:0] & `AFELM_MASK_LINE;
      end else if (hit_sample) begin
        sample_edge_detect_ctrl <= pwdata_i[7:0] & `AFELM_MASK_SAMPLE;
      end else if (hit_power) begin
        selective_power_disable <= pwdata_i[7:0] & `AFELM_MASK_POWER;
      end else if (hit_base) begin
        base_setup <= pwdata_i[7:0] & `AFELM_MASK_BASE;
      end
    end
  end

  // Cycle counter; a reset write beats a coincident pin pulse
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cycle_colour <= AFELM_RED;
    end else if (cycle_reset_wr) begin
      cycle_colour <= AFELM_RED;
    end else if (ce_i && auto_cycle && clamp_rise) begin
      cycle_colour <= next_colour;
    end
  end

  // Registered controls
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mono_o <= 1'b0;
      mono_channel_o <= 2'b00;
      input_mux_sel_o <= 2'b00;
      gain_offset_sel_o <= 2'b00;
      clamp_enable_o <= 1'b0;
      timing_strobe_o <= 1'b0;
      cell_enable_o <= 4'hF;
    end else if (ce_i) begin
      mono_o <= next_mono;
      mono_channel_o <= next_channel;
      input_mux_sel_o <= next_input_sel;
      gain_offset_sel_o <= next_gain_sel;
      clamp_enable_o <= next_clamp;
      timing_strobe_o <= next_strobe;
      cell_enable_o <= next_cells;
    end
  end

  // Read mux
  wire [31:0] status_word = {20'h00000, cell_enable_o, timing_strobe_o, clamp_enable_o,
                             gain_offset_sel_o, input_mux_sel_o, cycle_colour};
  wire [31:0] rd_line = {24'h000000, line_mode_colour_select};
  wire [31:0] rd_sample = {24'h000000, sample_edge_detect_ctrl};
  wire [31:0] rd_power = {24'h000000, selective_power_disable};
  wire [31:0] rd_base = {24'h000000, base_setup};
  assign prdata_o = hit_line ? rd_line :
                    hit_sample ? rd_sample :
                    hit_power ? rd_power :
                    hit_base ? rd_base :
                    hit_status ? status_word : 32'h00000000;

  // Checks
  a_mono_forced: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    ce_i && line_en |=> mono_o && mono_channel_o == 2'b00)
    else $error("line mode did not force mono timing");

  a_gb_gain_off: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    ce_i && line_en |=> !cell_enable_o[1] && !cell_enable_o[2])
    else $error("green or blue gain active in line mode");

  a_cycle_step: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    ce_i && auto_cycle && clamp_rise && !cycle_reset_wr && cycle_colour == AFELM_BLUE
    |=> cycle_colour == AFELM_RED)
    else $error("cycle counter did not wrap to red");

  a_cycle_hold: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !auto_cycle && !cycle_reset_wr |=> $stable(cycle_colour))
    else $error("cycle counter moved outside auto-cycling");

  a_cycle_reset: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    cycle_reset_wr |=> cycle_colour == AFELM_RED)
    else $error("cycle reset write ignored");

  a_clamp_internal: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    ce_i && auto_cycle |=> clamp_enable_o == $past(internal_clamp_enable))
    else $error("clamp not from internal bit while cycling");

  a_force_input: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    ce_i && force_input_enable |=> input_mux_sel_o == $past(forced_input_select))
    else $error("forced input not applied");

  a_strobe_pass: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    ce_i && !sample_detect_enable |=> timing_strobe_o == $past(strobe_sync))
    else $error("strobe not passed through");

  a_disable_cells: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    ce_i && selective_powerdown_enable && !line_en |=> cell_enable_o == ~$past(cell_disable_bits))
    else $error("selective disable bits not applied");

  a_global_power: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    ce_i && !selective_powerdown_enable && !line_en |=> cell_enable_o == {4{$past(global_enable)}})
    else $error("global enable not governing power");
endmodule
`default_nettype wire

/* include/afelm_consts.svh */
// Register offsets, field positions, reset values and sizes of the line mode control block
`ifndef AFELM_CONSTS_SVH
`define AFELM_CONSTS_SVH

`define AFELM_ADDR_W 8
`define AFELM_OFS_LINE 8'h00
`define AFELM_OFS_SAMPLE 8'h04
`define AFELM_OFS_POWER 8'h08
`define AFELM_OFS_CYCRST 8'h0C
`define AFELM_OFS_BASE 8'h10
`define AFELM_OFS_STATUS 8'h14

`define AFELM_RST_LINE 8'h00
`define AFELM_RST_SAMPLE 8'h00
`define AFELM_RST_POWER 8'h00
`define AFELM_RST_BASE 8'h01

`define AFELM_MASK_LINE 8'hFF
`define AFELM_MASK_SAMPLE 8'h1F
`define AFELM_MASK_POWER 8'h0F
`define AFELM_MASK_BASE 8'hCD

`define AFELM_LINE_EN_BIT 0
`define AFELM_LINE_CYC_BIT 1
`define AFELM_LINE_FORCE_BIT 2
`define AFELM_LINE_CLAMP_BIT 3
`define AFELM_LINE_ICOL_LSB 4
`define AFELM_LINE_FSEL_LSB 6
`define AFELM_SMP_DET_BIT 0
`define AFELM_SMP_DLY_LSB 1
`define AFELM_SMP_POL_BIT 4
`define AFELM_BASE_EN_BIT 0
`define AFELM_BASE_MONO_BIT 2
`define AFELM_BASE_SPD_BIT 3
`define AFELM_BASE_MCH_LSB 6

`define AFELM_DLY_W 3
`define AFELM_DLY_DEPTH 8

`endif

/* include/afelm_pkg.sv */
// Types shared by the line mode control block
`default_nettype none
package afelm_pkg;
  typedef enum logic [1:0] {
    AFELM_RED,
    AFELM_GREEN,
    AFELM_BLUE,
    AFELM_RSVD
  } afelm_colour_e;
endpackage
`default_nettype wire

/* design/afelm_sample_delay.sv */
// Edge detector and programmable delay line for the sample strobe
`include "afelm_consts.svh"
`default_nettype none
module afelm_sample_delay #(
  parameter int DEPTH = `AFELM_DLY_DEPTH,
  parameter int DLY_W = `AFELM_DLY_W
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Synchronised strobe level and settings
  input wire logic level_i,
  input wire logic rising_i,
  input wire logic [DLY_W-1:0] delay_i,
  // Delayed one-cycle pulse
  output logic pulse_o
);
  logic prev;
  logic [DEPTH-1:0] pipe;
  wire edge_seen;

  assign edge_seen = rising_i ? (level_i & ~prev) : (~level_i & prev);

  // Shift line keeps overlapping edges apart
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev <= 1'b0;
      pipe <= '0;
    end else if (ce_i) begin
      prev <= level_i;
      pipe <= {pipe[DEPTH-2:0], edge_seen};
    end
  end

  assign pulse_o = pipe[delay_i];

  sequence s_edge_d2;
    ce_i && edge_seen && delay_i == 3'h2;
  endsequence
  sequence s_hold_d2;
    (ce_i && delay_i == 3'h2) [*2];
  endsequence
  // Tap two is loaded by the third shift after the edge
  a_delay_two: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    s_edge_d2 ##1 s_hold_d2 ##1 (delay_i == 3'h2) |-> pulse_o)
    else $error("delayed pulse missing after two periods");
endmodule
`default_nettype wire

/* sim/afelm_host_model.sv */
// Host side driver of the clamp/cycle and sample strobe pins
`default_nettype none
module afelm_host_model (
  // Clock
  input wire logic ref_clk_i,
  // Pins
  output logic clamp_cycle_pin_o,
  output logic sample_strobe_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    clamp_cycle_pin_o = 1'b0;
    sample_strobe_pin_o = 1'b0;
  end
  // Pins move only just after a rising edge, then hold
  task automatic drive(input logic clamp, input logic strobe, input int hold);
    @(posedge ref_clk_i);
    clamp_cycle_pin_o <= clamp;
    sample_strobe_pin_o <= strobe;
    repeat (hold) @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

/* sim/afe_line_mode_sample_sync_ctrl_test.sv */
// Self-checking bench of the line mode control block
`include "afelm_consts.svh"
`default_nettype none
module afe_line_mode_sample_sync_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 0, arst_n_i = 0, ce_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, l, b, p, s;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, mono, clamp, strobe, cpin, spin, pol, acc, lv;
  logic [1:0] mch, insel, gsel;
  logic [11:0] e;
  logic [3:0] cells;
  int error_cnt = 0, samples_checked = 0, cyc = 0, m;
  afelm_ctrl u_afelm_ctrl (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .clamp_cycle_pin_i(cpin), .sample_strobe_pin_i(spin),
    .mono_o(mono), .mono_channel_o(mch), .input_mux_sel_o(insel), .gain_offset_sel_o(gsel),
    .clamp_enable_o(clamp), .timing_strobe_o(strobe), .cell_enable_o(cells));
  afelm_host_model u_afelm_host_model (.ref_clk_i(ref_clk_i), .clamp_cycle_pin_o(cpin),
    .sample_strobe_pin_o(spin));
  initial forever #20 ref_clk_i = ~ref_clk_i;
  // Expected {mono, chan, input sel, gain sel, clamp, enables}
  function automatic logic [11:0] exp_out(logic [7:0] l, logic [7:0] b, logic [7:0] p, logic pin);
    logic ln;
    logic [1:0] g;
    logic [1:0] i;
    logic [3:0] c;
    ln = l[0];
    g = !ln ? b[7:6] : (l[1] ? 2'b00 : l[5:4]);
    i = (ln && l[2]) ? l[7:6] : g;
    c = b[3] ? ~p[3:0] : {4{b[0]}};
    if (ln) c[2:1] = 2'b00;
    return {ln | b[2], ln ? 2'b00 : b[7:6], i, g, (ln && l[1]) ? l[3] : pin, c};
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk("rdata", rd, e);
    chk("pslverr", err, ee);
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(61589));
    repeat (10) @(posedge ref_clk_i);
    chk("rst_outs", {mono, mch, insel, gsel, clamp, strobe, cells}, 13'h000F);
    arst_n_i <= 1'b1;
    rdchk(`AFELM_OFS_LINE, `AFELM_RST_LINE, 1'b0);
    rdchk(`AFELM_OFS_SAMPLE, `AFELM_RST_SAMPLE, 1'b0);
    rdchk(`AFELM_OFS_POWER, `AFELM_RST_POWER, 1'b0);
    rdchk(`AFELM_OFS_BASE, `AFELM_RST_BASE, 1'b0);
    rdchk(8'h18, 32'h0, 1'b1);
    wr(8'h18, 32'hFF);
    chk("wr_err", err, 1'b1);
    wr(`AFELM_OFS_SAMPLE, 32'hFFFF_FFFF);
    rdchk(`AFELM_OFS_SAMPLE, 32'h1F, 1'b0);
    wr(`AFELM_OFS_POWER, 32'hFFFF_FFFF);
    rdchk(`AFELM_OFS_POWER, 32'h0F, 1'b0);
    for (int k = 0; k < 16; k++) begin
      l = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
      b = 8'($urandom);
      p = 8'($urandom) & 8'h0F;
      s = 8'($urandom) & 8'h1E;
      lv = 1'($urandom);
      u_afelm_host_model.drive(lv, lv, 0);
      wr(`AFELM_OFS_LINE, l);
      wr(`AFELM_OFS_BASE, b);
      wr(`AFELM_OFS_POWER, p);
      wr(`AFELM_OFS_SAMPLE, s);
      wr(`AFELM_OFS_CYCRST, $urandom);
      repeat (3) @(posedge ref_clk_i);
      chk("outs", {mono, mch, insel, gsel, clamp, cells}, exp_out(l, b, p, lv));
      chk("strobe_raw", strobe, lv);
    end
    wr(`AFELM_OFS_LINE, 8'h03);
    u_afelm_host_model.drive(1'b0, 1'b0, 3);
    wr(`AFELM_OFS_CYCRST, 32'h0);
    for (int k = 1; k < 5; k++) begin
      u_afelm_host_model.drive(1'b1, 1'b0, 2);
      u_afelm_host_model.drive(1'b0, 1'b0, 3);
      chk("cycle_sel", {insel, gsel}, {2{2'(k % 3)}});
    end
    wr(`AFELM_OFS_LINE, 8'h87);
    repeat (2) @(posedge ref_clk_i);
    chk("force_sel", {insel, gsel}, 4'b1001);
    wr(`AFELM_OFS_CYCRST, 32'h0);
    repeat (2) @(posedge ref_clk_i);
    chk("cyc_reset", gsel, 2'b00);
    // Status word: enables, strobe, clamp, gain sel, input sel, counter
    e = exp_out(8'h87, b, p, 1'b0);
    rdchk(`AFELM_OFS_STATUS, {20'h00000, e[3:0], 1'b0, e[4], e[6:5], e[8:7], 2'b00}, 1'b0);
    rdchk(`AFELM_OFS_CYCRST, 32'h0, 1'b0);
    // A pin pulse while the enable is low must not reach the counter
    ce_i <= 1'b0;
    u_afelm_host_model.drive(1'b1, 1'b0, 2);
    u_afelm_host_model.drive(1'b0, 1'b0, 3);
    chk("pready_low", pready, 1'b0);
    ce_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    chk("ce_freeze", gsel, 2'b00);
    chk("pready_high", pready, 1'b1);
    for (int d = 0; d < 8; d++) begin
      pol = 1'($urandom);
      wr(`AFELM_OFS_SAMPLE, 32'({pol, 3'(d), 1'b1}));
      u_afelm_host_model.drive(1'b0, !pol, 0);
      acc = 1'b0;
      repeat (14) begin
        @(negedge ref_clk_i);
        acc = acc | strobe;
      end
      chk("wrong_edge", acc, 1'b0);
      u_afelm_host_model.drive(1'b0, pol, 0);
      m = 0;
      while (strobe !== 1'b1 && m < 20) begin
        @(posedge ref_clk_i);
        m++;
        @(negedge ref_clk_i);
      end
      chk("delay", m, d + 4);
      @(negedge ref_clk_i);
      chk("width", strobe, 1'b0);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
